/* File: design/skgc_ctrl.sv */
/*
  Sidetone, keyclick and DAC gain soft-step control with an APB slave,
  a sticky interrupt status and one level interrupt.
  Assumes frame_clock and st_zero_cross are synchronous to core_clk.
*/
// The APB slave port was decided locally.
`timescale 1ns/1ps
module skgc_ctrl
  import skgc_pkg::*;
#(
  parameter int CLICK_BASE_HALF = BASE_HALF_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_clock,
  input  wire logic        st_zero_cross,
  output logic             sidetone_mute,
  output logic [6:0]       sidetone_gain_applied,
  output logic [6:0]       left_gain_applied,
  output logic [6:0]       right_gain_applied,
  output logic             click_tone,
  output logic [2:0]       click_amplitude,
  output logic             irq
);

  // ==========================================================
  // Bus decode
  logic [7:0] idx;
  wire        setup_ph;
  wire        acc_wr;
  wire        mapped;
  wire [15:0] wd;

  assign idx      = paddr[9:2];
  assign setup_ph = psel && !penable;
  assign acc_wr   = psel && penable && pwrite;
  assign wd       = pwdata[15:0];
  assign mapped   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                    ((idx == IDX_VOLUME) || (idx == IDX_SIDE) ||
                     (idx == IDX_CLICK) || (idx == IDX_IRQ_ST) ||
                     (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_EN));

  wire wr_vol    = acc_wr && mapped && (idx == IDX_VOLUME);
  wire wr_side   = acc_wr && mapped && (idx == IDX_SIDE);
  wire wr_click  = acc_wr && mapped && (idx == IDX_CLICK);
  wire wr_irqclr = acc_wr && mapped && (idx == IDX_IRQ_CLR);
  wire wr_irqen  = acc_wr && mapped && (idx == IDX_IRQ_EN);

  // ==========================================================
  // Control registers
  logic       mute_ff;
  logic [6:0] st_gain_ff;
  logic       click_en_ff;
  logic [2:0] amp_ff;
  logic [2:0] frq_ff;
  logic [3:0] len_ff;
  logic       rate_ff;
  logic [6:0] left_vol_ff;
  logic [6:0] right_vol_ff;
  logic       nxt_click_en;
  wire        click_done;

  assign nxt_click_en = (wr_click && wd[CLK_EN_BIT]) ? 1'b1 :
                        wr_click ? 1'b0 :
                        click_done ? 1'b0 : click_en_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mute_ff    <= 1'b1;
      st_gain_ff <= SIDE_GAIN_RST;
    end else if (wr_side) begin
      mute_ff    <= wd[SIDE_MUTE_BIT];
      st_gain_ff <= wd[SIDE_GAIN_LSB +: 7];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      amp_ff  <= CLK_AMP_RST;
      frq_ff  <= CLK_FRQ_RST;
      len_ff  <= CLK_LEN_RST;
      rate_ff <= 1'b0;
    end else if (wr_click) begin
      amp_ff  <= wd[CLK_AMP_LSB +: 3];
      frq_ff  <= wd[CLK_FRQ_LSB +: 3];
      len_ff  <= wd[CLK_LEN_LSB +: 4];
      rate_ff <= wd[CLK_RATE_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      click_en_ff <= 1'b0;
    end else begin
      click_en_ff <= nxt_click_en;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      left_vol_ff  <= VOL_RST;
      right_vol_ff <= VOL_RST;
    end else if (wr_vol) begin
      left_vol_ff  <= wd[VOL_LEFT_LSB +: 7];
      right_vol_ff <= wd[VOL_RIGHT_LSB +: 7];
    end
  end

  // ==========================================================
  // Sidetone gain applied at zero crossings
  logic [6:0] st_applied_ff;
  logic       st_done_ff;
  logic [6:0] nxt_st_applied;
  logic       nxt_st_done;

  assign nxt_st_applied = st_zero_cross ? st_gain_ff : st_applied_ff;
  assign nxt_st_done = wr_side ? 1'b0 : (nxt_st_applied == st_gain_ff);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_applied_ff <= SIDE_GAIN_RST;
      st_done_ff    <= 1'b0;
    end else begin
      st_applied_ff <= nxt_st_applied;
      st_done_ff    <= nxt_st_done;
    end
  end

  assign sidetone_gain_applied = (st_applied_ff > SIDE_GAIN_MAX) ?
                                 SIDE_GAIN_MAX : st_applied_ff;
  assign sidetone_mute = mute_ff;

  // ==========================================================
  // Frame clock step timing
  logic frame_prev_ff;
  logic half_rate_ff;
  wire  frame_rise;
  wire  step_tick;

  assign frame_rise = frame_clock && !frame_prev_ff;
  // every frame or every second frame
  assign step_tick  = frame_rise && (!rate_ff || half_rate_ff);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      frame_prev_ff <= 1'b0;
      half_rate_ff  <= 1'b0;
    end else begin
      frame_prev_ff <= frame_clock;
      if (frame_rise) begin
        half_rate_ff <= ~half_rate_ff;
      end
    end
  end

  // ==========================================================
  // Channel trackers
  skgc_step_if left_if ();
  skgc_step_if right_if ();

  assign left_if.target     = left_vol_ff;
  assign left_if.target_wr  = wr_vol;
  assign left_if.step_tick  = step_tick;
  assign right_if.target    = right_vol_ff;
  assign right_if.target_wr = wr_vol;
  assign right_if.step_tick = step_tick;

  skgc_gain_step u_left (
    .core_clk (core_clk),
    .rstn     (rstn),
    .st       (left_if.trk)
  );

  skgc_gain_step u_right (
    .core_clk (core_clk),
    .rstn     (rstn),
    .st       (right_if.trk)
  );

  assign left_gain_applied  = left_if.applied;
  assign right_gain_applied = right_if.applied;

  // ==========================================================
  // Keyclick tone
  skgc_click_gen #(
    .BASE_HALF (CLICK_BASE_HALF)
  ) u_click (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .run       (click_en_ff),
    .freq_code (frq_ff),
    .len_code  (len_ff),
    .tone      (click_tone),
    .done      (click_done)
  );

  assign click_amplitude = amp_ff;

  // ==========================================================
  // Interrupt status, clear and enable
  logic [EV_NUM-1:0] irq_st_ff;
  logic [EV_NUM-1:0] irq_en_ff;
  logic              st_done_d_ff;
  logic              l_done_d_ff;
  logic              r_done_d_ff;
  logic [EV_NUM-1:0] events;
  logic [EV_NUM-1:0] clr_bits;
  logic [EV_NUM-1:0] nxt_irq_st;

  assign events[EV_SIDE]  = st_done_ff && !st_done_d_ff;
  assign events[EV_LEFT]  = left_if.done && !l_done_d_ff;
  assign events[EV_RIGHT] = right_if.done && !r_done_d_ff;
  assign events[EV_CLICK] = click_done;
  assign clr_bits   = wr_irqclr ? wd[EV_NUM-1:0] : '0;
  assign nxt_irq_st = (irq_st_ff & ~clr_bits) | events;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_st_ff    <= '0;
      irq_en_ff    <= '0;
      st_done_d_ff <= 1'b0;
      l_done_d_ff  <= 1'b0;
      r_done_d_ff  <= 1'b0;
    end else begin
      irq_st_ff    <= nxt_irq_st;
      st_done_d_ff <= st_done_ff;
      l_done_d_ff  <= left_if.done;
      r_done_d_ff  <= right_if.done;
      if (wr_irqen) begin
        irq_en_ff <= wd[EV_NUM-1:0];
      end
    end
  end

  assign irq = |(irq_st_ff & irq_en_ff);

  // ==========================================================
  // Read data, captured in the setup phase
  logic [15:0] side_rd;
  logic [15:0] click_rd;
  logic [15:0] vol_rd;
  logic [15:0] rd_sel;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;

  assign side_rd = {mute_ff, st_gain_ff, SIDE_RSVD_ONES, st_done_ff};
  assign click_rd = {click_en_ff, amp_ff, 1'b0, frq_ff, len_ff,
                     left_if.done, right_if.done, rate_ff, 1'b0};
  assign vol_rd   = {1'b0, left_vol_ff, 1'b0, right_vol_ff};

  assign rd_sel = (idx == IDX_SIDE)   ? side_rd :
                  (idx == IDX_CLICK)  ? click_rd :
                  (idx == IDX_VOLUME) ? vol_rd :
                  (idx == IDX_IRQ_ST) ? {12'h000, irq_st_ff} :
                  (idx == IDX_IRQ_EN) ? {12'h000, irq_en_ff} :
                  16'h0000;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff  <= (mapped && !pwrite) ? {16'h0000, rd_sel} :
                    32'h00000000;
      pslverr_ff <= !mapped;
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;
  assign pready  = 1'b1;

endmodule

/* File: design/skgc_pkg.sv */
/*
  Constants for the sidetone, keyclick and gain soft-step control block:
  register indices, field positions, reset values and timing counts.
  Assumes a 50 MHz core clock and an APB master with 32-bit data.
*/
package skgc_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_VOLUME  = 8'h02;
  localparam logic [7:0] IDX_SIDE    = 8'h03;
  localparam logic [7:0] IDX_CLICK   = 8'h04;
  localparam logic [7:0] IDX_IRQ_ST  = 8'h08;
  localparam logic [7:0] IDX_IRQ_CLR = 8'h09;
  localparam logic [7:0] IDX_IRQ_EN  = 8'h0A;

  // ==========================================================
  // Field positions
  localparam int SIDE_MUTE_BIT  = 15;
  localparam int SIDE_GAIN_LSB  = 8;
  localparam int SIDE_DONE_BIT  = 0;
  localparam int CLK_EN_BIT     = 15;
  localparam int CLK_AMP_LSB    = 12;
  localparam int CLK_FRQ_LSB    = 8;
  localparam int CLK_LEN_LSB    = 4;
  localparam int CLK_LDONE_BIT  = 3;
  localparam int CLK_RDONE_BIT  = 2;
  localparam int CLK_RATE_BIT   = 1;
  localparam int VOL_LEFT_LSB   = 8;
  localparam int VOL_RIGHT_LSB  = 0;

  // ==========================================================
  // Reset values and gain limits
  localparam logic [6:0]  SIDE_GAIN_RST  = 7'h45;
  localparam logic [6:0]  SIDE_GAIN_MAX  = 7'h5D;
  localparam logic [6:0]  SIDE_RSVD_ONES = 7'h7F;
  localparam logic [2:0]  CLK_AMP_RST    = 3'h4;
  localparam logic [2:0]  CLK_FRQ_RST    = 3'h4;
  localparam logic [3:0]  CLK_LEN_RST    = 4'h1;
  localparam logic [6:0]  VOL_RST        = 7'h7F;

  // ==========================================================
  // Interrupt status layout
  localparam int EV_SIDE  = 0;
  localparam int EV_LEFT  = 1;
  localparam int EV_RIGHT = 2;
  localparam int EV_CLICK = 3;
  localparam int EV_NUM   = 4;

  // ==========================================================
  // Timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int BASE_TONE_DHZ  = 625;
  localparam int BASE_HALF_CYC  = (CLK_HZ * 10) / (2 * BASE_TONE_DHZ);

endpackage

/* File: design/skgc_step_if.sv */
/*
  Carrier between the controller and one gain soft-step tracker.
  Assumes one tracker per DAC channel, all on core_clk.
*/
`timescale 1ns/1ps
interface skgc_step_if;
  logic [6:0] target;
  logic       target_wr;
  logic       step_tick;
  logic [6:0] applied;
  logic       done;

  modport ctl (output target, output target_wr, output step_tick,
               input applied, input done);
  modport trk (input target, input target_wr, input step_tick,
               output applied, output done);
endinterface

/* File: design/skgc_gain_step.sv */
/*
  Soft-step tracker: moves an applied 7-bit gain code one step toward its
  target on each step tick and reports when the two match.
  Assumes step_tick is a one-cycle pulse from the controller.
*/
`timescale 1ns/1ps
module skgc_gain_step
  import skgc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rstn,
  skgc_step_if.trk  st
);

  logic [6:0] applied_ff;
  logic [6:0] nxt_applied;
  logic       done_ff;
  logic       nxt_done;
  wire        going_up = st.target > applied_ff;
  wire        going_dn = st.target < applied_ff;

  assign nxt_applied = !st.step_tick ? applied_ff :
                       going_up ? applied_ff + 7'h01 :
                       going_dn ? applied_ff - 7'h01 : applied_ff;
  // flag drops on a new target
  assign nxt_done = st.target_wr ? 1'b0 : (nxt_applied == st.target);

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      applied_ff <= VOL_RST;
      done_ff    <= 1'b0;
    end else begin
      applied_ff <= nxt_applied;
      done_ff    <= nxt_done;
    end
  end

  assign st.applied = applied_ff;
  assign st.done    = done_ff;

endmodule

/* File: design/skgc_click_gen.sv */
/*
  Keyclick square-tone generator: toggles the tone every half period and
  pulses done after 2 * (len_code + 1) whole periods.
  Assumes run stays high until done has been seen by the controller.
*/
`timescale 1ns/1ps
module skgc_click_gen
  import skgc_pkg::*;
#(
  parameter int BASE_HALF = BASE_HALF_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic [2:0] freq_code,
  input  wire logic [3:0] len_code,
  output logic            tone,
  output logic            done
);

  logic [19:0] cyc_ff;
  logic [6:0]  halves_ff;
  logic        tone_ff;
  logic [19:0] half_len;
  logic [6:0]  halves_all;
  wire         half_end;
  wire         last_half;

  assign half_len   = 20'(BASE_HALF >> freq_code);
  assign halves_all = {1'b0, len_code, 2'b00} + 7'h04;
  assign half_end   = run && (cyc_ff >= half_len - 20'h00001);
  assign last_half  = half_end && (halves_ff == halves_all - 7'h01);
  assign done       = last_half;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cyc_ff    <= 20'h00000;
      halves_ff <= 7'h00;
      tone_ff   <= 1'b0;
    end else if (!run || last_half) begin
      cyc_ff    <= 20'h00000;
      halves_ff <= 7'h00;
      tone_ff   <= 1'b0;
    end else if (half_end) begin
      cyc_ff    <= 20'h00000;
      halves_ff <= halves_ff + 7'h01;
      tone_ff   <= ~tone_ff;
    end else begin
      cyc_ff    <= cyc_ff + 20'h00001;
    end
  end

  assign tone = tone_ff;

endmodule

/* File: sim/skgc_ctrl_assertions.sv */
/*
  Concurrent checks on the skgc_ctrl ports.
  Assumes CLICK_BASE_HALF of 1024 or more, so a tone half lasts 8+ cycles.
*/
`timescale 1ns/1ps
module skgc_ctrl_assertions
  import skgc_pkg::*;
#(
  parameter int CLICK_BASE_HALF = BASE_HALF_CYC
) (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_clock,
  input wire logic        st_zero_cross,
  input wire logic        sidetone_mute,
  input wire logic [6:0]  sidetone_gain_applied,
  input wire logic [6:0]  left_gain_applied,
  input wire logic [6:0]  right_gain_applied,
  input wire logic        click_tone,
  input wire logic [2:0]  click_amplitude,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Sequences
  sequence frame_quiet;
    !frame_clock [*4];
  endsequence

  // ==========================================================
  // Assertions
  reset_vals_a:
    assert property ($rose(rstn) |-> sidetone_mute &&
      sidetone_gain_applied == 7'h45 && click_amplitude == 3'h4)
    else $error("wrong output value after reset");
  gain_clamp_a:
    assert property (sidetone_gain_applied <= 7'h5D)
    else $error("sidetone gain above maximum");
  gain_hold_a:
    assert property (!st_zero_cross |=> $stable(sidetone_gain_applied))
    else $error("sidetone gain moved without zero crossing");
  step_frame_a:
    assert property (frame_quiet |=> $stable(left_gain_applied) &&
      $stable(right_gain_applied))
    else $error("gain stepped without frame edge");
  step_size_a:
    assert property ($changed(left_gain_applied) |->
      left_gain_applied == $past(left_gain_applied) + 7'h01 ||
      left_gain_applied == $past(left_gain_applied) - 7'h01)
    else $error("left gain step not one code");
  tone_half_a:
    assert property ($changed(click_tone) |=> $stable(click_tone) [*7])
    else $error("tone half period too short");
  apb_ready_a:
    assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  apb_err_a:
    assert property (pslverr |-> psel && penable && prdata == 32'h0)
    else $error("error response outside access or with data");
  apb_upper_a:
    assert property (psel && penable |-> prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
endmodule

/* File: sim/skgc_ctrl_tb.sv */
/*
  Self-checking testbench for skgc_ctrl: APB registers, sidetone gain,
  soft-step, keyclick and interrupt. Assumes zero-wait APB slave.
*/
`timescale 1ns/1ps
module skgc_ctrl_tb;
  import skgc_pkg::*;
  localparam int HALF = 1024;
  logic        core_clk, rstn, psel, penable, pwrite;
  logic        frame_clock, st_zero_cross, pready, pslverr;
  logic        sidetone_mute, click_tone, irq, err, t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  st_g, l_g, r_g, pv;
  logic [2:0]  amp;
  logic [13:0] st_rows [5];
  logic [6:0]  ck_rows [9];
  int          fail_count, check_count, n, h;

  skgc_ctrl #(.CLICK_BASE_HALF(HALF)) DUT (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_clock(frame_clock),
    .st_zero_cross(st_zero_cross), .sidetone_mute(sidetone_mute),
    .sidetone_gain_applied(st_g), .left_gain_applied(l_g),
    .right_gain_applied(r_g), .click_tone(click_tone),
    .click_amplitude(amp), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] e, a);
    check_count++;
    if (a !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [15:0] d);
    logic rdy;
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {16'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      {rd, err, rdy} = {prdata, pslverr, pready};
    end while (rdy !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge core_clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] i,
                      input logic [15:0] e);
    apb(1'b0, i, 16'h0);
    chk(nm, {16'h0, e}, rd);
  endtask

  task automatic frames(input int k);
    repeat (k) begin
      frame_clock <= 1'b1;
      repeat (3) @(posedge core_clk);
      frame_clock <= 1'b0;
      repeat (5) @(posedge core_clk);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    #1ms;
    fail_count++;
    end_of_test();
  end

  initial begin
    {rstn, psel, penable, pwrite, frame_clock, st_zero_cross} = 6'h0;
    {paddr, pwdata} = 44'h0;
    st_rows = '{14'h0000, 14'h2F5D, 14'h2EDD, 14'h3FDD, 14'h22C5};
    ck_rows = '{7'h00, 7'h10, 7'h20, 7'h30, 7'h40, 7'h50, 7'h60,
                7'h70, 7'h7F};
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk("volume", IDX_VOLUME, 16'h7F7F);
    rchk("sidetone", IDX_SIDE, 16'hC5FF);
    rchk("click", IDX_CLICK, 16'h441C);
    chk("mute", 1, sidetone_mute);
    pv = 7'h45;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, IDX_SIDE, {1'b0, st_rows[i][13:7], 8'hFE});
      rchk("st_flag0", IDX_SIDE, {1'b0, st_rows[i][13:7], 8'hFE});
      chk("st_held", pv, st_g);
      st_zero_cross <= 1'b1;
      @(posedge core_clk);
      st_zero_cross <= 1'b0;
      @(posedge core_clk);
      pv = st_rows[i][6:0];
      chk("st_gain", pv, st_g);
      rchk("st_flag1", IDX_SIDE, {1'b0, st_rows[i][13:7], 8'hFF});
      chk("unmute", 0, sidetone_mute);
    end
    apb(1'b1, IDX_SIDE, 16'hC5FE);
    chk("mute", 1, sidetone_mute);
    apb(1'b1, IDX_VOLUME, 16'h7D7E);
    rchk("vol_flags", IDX_CLICK, 16'h4410);
    frames(1);
    chk("left", 7'h7E, l_g);
    chk("right", 7'h7E, r_g);
    rchk("r_done", IDX_CLICK, 16'h4414);
    frames(1);
    rchk("l_done", IDX_CLICK, 16'h441C);
    apb(1'b1, IDX_CLICK, 16'h4412);
    apb(1'b1, IDX_VOLUME, 16'h7B7E);
    frames(2);
    chk("slow1", 7'h7C, l_g);
    frames(2);
    chk("slow2", 7'h7B, l_g);
    apb(1'b1, IDX_IRQ_CLR, 16'h000F);
    apb(1'b1, IDX_IRQ_EN, 16'h0008);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, IDX_CLICK, {1'b1, ck_rows[i][6:4], 1'b0, ck_rows[i], 4'h0});
      chk("amp", ck_rows[i][6:4], amp);
      n = 0;
      h = 0;
      t = 1'b0;
      for (int c = 0; c < 9000 && irq !== 1'b1; c++) begin
        @(posedge core_clk);
        n += (click_tone === 1'b1 && t === 1'b0);
        h += (click_tone === 1'b1);
        t = click_tone;
      end
      chk("periods", 2 * (ck_rows[i][3:0] + 1), n);
      chk("high", 2 * (ck_rows[i][3:0] + 1) * (HALF >> ck_rows[i][6:4]),
          h);
      chk("irq", 1, irq);
      rchk("en_clr", IDX_CLICK, {1'b0, ck_rows[i][6:4], 1'b0,
           ck_rows[i], 4'hC});
      if (i < 8) apb(1'b1, IDX_IRQ_CLR, 16'h0008);
    end
    apb(1'b1, IDX_IRQ_EN, 16'h0000);
    chk("masked", 0, irq);
    apb(1'b1, IDX_IRQ_EN, 16'h0008);
    chk("unmasked", 1, irq);
    apb(1'b1, IDX_IRQ_CLR, 16'h0008);
    chk("cleared", 0, irq);
    apb(1'b0, 8'h3F, 16'h0);
    chk("slverr", 1, err);
    chk("err_data", 0, rd);
    // ==========================================================
    // Reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("rst_irq", 0, irq);
    chk("rst_mute", 1, sidetone_mute);
    chk("rst_left", 7'h7F, l_g);
    rchk("rst_side", IDX_SIDE, 16'hC5FF);
    end_of_test();
  end
endmodule

bind skgc_ctrl skgc_ctrl_assertions #(
  .CLICK_BASE_HALF(CLICK_BASE_HALF)
) u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frame_clock(frame_clock),
  .st_zero_cross(st_zero_cross), .sidetone_mute(sidetone_mute),
  .sidetone_gain_applied(sidetone_gain_applied),
  .left_gain_applied(left_gain_applied),
  .right_gain_applied(right_gain_applied), .click_tone(click_tone),
  .click_amplitude(click_amplitude), .irq(irq));
